// file: include/xg_defines.svh
// Register offsets, field positions, codes and constants of the extended-state guard
`ifndef XG_DEFINES_SVH
`define XG_DEFINES_SVH
`define XG_REG_CTRL      8'h00
`define XG_REG_MASK_LO   8'h04
`define XG_REG_MASK_HI   8'h08
`define XG_REG_XCR_LO    8'h0C
`define XG_REG_XCR_HI    8'h10
`define XG_REG_PAGES     8'h14
`define XG_REG_MISC      8'h18
`define XG_REG_ASEL_LO   8'h1C
`define XG_REG_ASEL_HI   8'h20
`define XG_REG_MSEL      8'h24
`define XG_REG_LFCS      8'h28
`define XG_REG_LBM_LO    8'h2C
`define XG_REG_LBM_HI    8'h30
`define XG_REG_CMD       8'h34
`define XG_REG_STATUS    8'h38
`define XG_REG_SXCR_LO   8'h3C
`define XG_REG_SXCR_HI   8'h40
`define XG_REG_MOD_LO    8'h44
`define XG_REG_MOD_HI    8'h48
`define XG_REG_RMASK_LO  8'h4C
`define XG_REG_RMASK_HI  8'h50
`define XG_REG_RMISC     8'h54
`define XG_REG_KMASK_LO  8'h58
`define XG_REG_KMASK_HI  8'h5C
`define XG_REG_KMISC     8'h60
`define XG_REG_MEM_IDX   8'h64
`define XG_REG_MEM_WLO   8'h68
`define XG_REG_MEM_WHI   8'h6C
`define XG_REG_SBM_LO    8'h70
`define XG_REG_SBM_HI    8'h74
`define XG_REG_SAVE_MAP  8'h78
`define XG_REG_LAST      8'h78
`define XG_CTL_SUP       0
`define XG_CTL_LEGACY    1
`define XG_CTL_OSX       2
`define XG_CTL_WIDE      3
`define XG_CTL_DUAL      4
`define XG_OP_CREATE     4'h0
`define XG_OP_ENTER      4'h1
`define XG_OP_RESUME     4'h2
`define XG_OP_EXIT       4'h3
`define XG_OP_AEX        4'h4
`define XG_OP_SMI        4'h5
`define XG_OP_REPORT     4'h6
`define XG_OP_KEY        4'h7
`define XG_OP_LEAVE      4'h8
`define XG_FLT_NONE      2'h0
`define XG_FLT_GP        2'h1
`define XG_FLT_UD        2'h2
`define XG_RESP_OKAY     2'h0
`define XG_RESP_DECERR   2'h3
`define XG_MASK_BASE     2'h3
`define XG_LEGACY_BYTES  32'h0000_0240
`define XG_PAGE_SHIFT    12
`define XG_IDX_FCS       7'h03
`define XG_IDX_BM        7'h40
`define XG_IDX_HDR       7'h41
`define XG_FCS_INIT      32'h0000_1F80
`define XG_FCS_RSVD      32'hFFFF_0000
`define XG_SAVE_MAP_OFS  16'h7EE0
`define XG_SMAP_EI_BIT   1
`endif

// file: include/xg_pkg.sv
// Types shared by the extended-state guard and its testbench
package xg_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SV_FCS, ST_SV_BM, ST_SV_HDR, ST_RD_FCS, ST_RD_BM, ST_RD_HDR, ST_RD_CHK
  } fsm_t;
  typedef struct packed {
    axil_rsp_t   rsp;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [4:0]  ctrl;
    logic [63:0] mask;
    logic [63:0] xcr;
    logic [15:0] pages;
    logic [31:0] misc;
    logic [63:0] attr_sel;
    logic [31:0] misc_sel;
    logic [31:0] live_fcs;
    logic [63:0] live_bm;
    logic [6:0]  mem_idx;
    logic [31:0] mem_wlo;
    fsm_t        fsm;
    logic [1:0]  fault;
    logic        in_enclave;
    logic        system_management_mode;
    logic        save_map_ei;
    logic        exit_reason_ei;
    logic        intr_ei;
    logic        wide_used;
    logic        smi_pend;
    logic [63:0] saved_xcr;
    logic [63:0] modified;
    logic [63:0] rep_mask;
    logic [31:0] rep_misc;
    logic [63:0] key_mask;
    logic [31:0] key_misc;
    logic [63:0] saved_bm;
    logic [31:0] rd_fcs;
    logic [63:0] rd_bm;
  } guard_state_t;
endpackage

// file: core/save_frame_mem.sv
// Save-frame word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module save_frame_mem #(
  parameter int DW    = 64,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  // No reset on the array: contents are undefined until a save or a direct frame write stores them
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// file: core/enclave_xstate_guard.sv
// Enclave extended-state guard with AXI4-Lite register access
// Function
// - Create faults unless mask low bits are 3
// - Without xsave: high mask bits or zero frame
// - With xsave: illegal load, bit 63, small frame
// - Entry faults on enable bits or mask superset
// - Entry saves control register, loads mask
// - Async exit saves state, bitmap within mask
// - Async exit restores control register from entry
// - Async exit synthesizes initialized enabled state
// - Resume faults under entry's conditions
// - Resume faults on bad save-area contents
// - Resume swaps register and restores saved state
// - Resume marks all enabled state modified
// - Exit restores register, no checks or synthesis
// - Report carries mask and misc selection
// - Key uses only selected mask/misc bits
// - Enclave instructions in management mode: invalid opcode
// - Management interrupt in enclave: exit, set save-map bit
// - Dual monitor: exit sets reason, interruptibility bits
// - Save-map flag reflects enclave exit, read-only
// - Without xsave: mask copy at byte 512
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "xg_defines.svh"
module enclave_xstate_guard #(
  parameter logic [63:0] SUPPORTED_FEATURES = 64'h0000_0000_0000_00FF,
  parameter int          FEATURE_BYTES      = 256,
  parameter int          SAVE_DEPTH         = 128
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire xg_pkg::axil_req_t axil_req,
  output xg_pkg::axil_rsp_t      axil_rsp
);
  import xg_pkg::*;

  guard_state_t s;
  guard_state_t next_s;
  logic         mem_we;
  logic [6:0]   mem_addr;
  logic [63:0]  mem_wdata;
  logic [63:0]  mem_rdata;
  logic [31:0]  rd_data;
  logic         cmd_go;
  logic [3:0]   cmd_op;
  logic         create_gp;
  logic         entry_gp;
  logic         res_bad;
  logic         sup;
  logic [31:0]  need_bytes;
  logic [31:0]  frame_bytes;
  logic [7:0]   waddr;
  logic [7:0]   raddr;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] pop(input logic [63:0] v);
    logic [31:0] c;
    c = '0;
    for (int i = 0; i < 64; i++) begin
      c = c + 32'(v[i]);
    end
    return c;
  endfunction

  function automatic logic is_instr(input logic [3:0] op);
    return (op <= `XG_OP_EXIT) || (op == `XG_OP_REPORT) || (op == `XG_OP_KEY);
  endfunction

  save_frame_mem #(
    .DW    (64),
    .DEPTH (SAVE_DEPTH),
    .AW    (7)
  ) u_frame (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  assign sup         = s.ctrl[`XG_CTL_SUP];
  assign waddr       = {s.aw_addr[7:2], 2'h0};
  assign raddr       = {axil_req.araddr[7:2], 2'h0};
  // Frame size is modelled as a legacy area plus a fixed size per enabled upper feature
  assign need_bytes  = `XG_LEGACY_BYTES + 32'(pop({1'b0, s.mask[62:2], 2'h0}) * FEATURE_BYTES);
  assign frame_bytes = 32'(s.pages) << `XG_PAGE_SHIFT;
  assign create_gp   = (s.mask[1:0] != `XG_MASK_BASE)
                    || (!sup && ((s.mask[63:2] != '0) || (s.pages == '0)))
                    || (sup && (((s.mask & ~SUPPORTED_FEATURES) != '0) || s.mask[63]
                                || (need_bytes > frame_bytes)));
  assign entry_gp    = !s.ctrl[`XG_CTL_LEGACY]
                    || (sup && ((!s.ctrl[`XG_CTL_OSX] && (s.mask != 64'(`XG_MASK_BASE)))
                                || ((s.mask & s.xcr) != s.mask)));
  // Checked regardless of the OS enable, as a standard restore would
  assign res_bad     = ((s.rd_bm & ~s.mask) != '0) || (mem_rdata != '0)
                    || ((s.rd_fcs & `XG_FCS_RSVD) != '0);
  assign cmd_op      = s.w_data[3:0];
  assign axil_rsp    = s.rsp;

  always_comb begin
    next_s    = s;
    mem_we    = 1'b0;
    mem_addr  = `XG_IDX_FCS;
    mem_wdata = '0;
    rd_data   = '0;
    cmd_go    = 1'b0;
    if (axil_req.awvalid && s.rsp.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = axil_req.awaddr[7:0];
    end
    if (axil_req.wvalid && s.rsp.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = axil_req.wdata;
      next_s.w_strb = axil_req.wstrb;
    end
    if (s.rsp.bvalid && axil_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
      next_s.aw_held    = 1'b0;
      next_s.w_held     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = (waddr > `XG_REG_LAST) ? `XG_RESP_DECERR : `XG_RESP_OKAY;
      case (waddr)
        `XG_REG_CTRL:    next_s.ctrl = 5'(wmerge(32'(s.ctrl), s.w_data, s.w_strb));
        `XG_REG_MASK_LO: next_s.mask[31:0] = wmerge(s.mask[31:0], s.w_data, s.w_strb);
        `XG_REG_MASK_HI: next_s.mask[63:32] = wmerge(s.mask[63:32], s.w_data, s.w_strb);
        `XG_REG_XCR_LO:  next_s.xcr[31:0] = wmerge(s.xcr[31:0], s.w_data, s.w_strb);
        `XG_REG_XCR_HI:  next_s.xcr[63:32] = wmerge(s.xcr[63:32], s.w_data, s.w_strb);
        `XG_REG_PAGES:   next_s.pages = 16'(wmerge(32'(s.pages), s.w_data, s.w_strb));
        `XG_REG_MISC:    next_s.misc = wmerge(s.misc, s.w_data, s.w_strb);
        `XG_REG_ASEL_LO: next_s.attr_sel[31:0] = wmerge(s.attr_sel[31:0], s.w_data, s.w_strb);
        `XG_REG_ASEL_HI: next_s.attr_sel[63:32] = wmerge(s.attr_sel[63:32], s.w_data, s.w_strb);
        `XG_REG_MSEL:    next_s.misc_sel = wmerge(s.misc_sel, s.w_data, s.w_strb);
        `XG_REG_LFCS:    next_s.live_fcs = wmerge(s.live_fcs, s.w_data, s.w_strb);
        `XG_REG_LBM_LO:  next_s.live_bm[31:0] = wmerge(s.live_bm[31:0], s.w_data, s.w_strb);
        `XG_REG_LBM_HI:  next_s.live_bm[63:32] = wmerge(s.live_bm[63:32], s.w_data, s.w_strb);
        `XG_REG_CMD:     cmd_go = (s.fsm == ST_IDLE);
        `XG_REG_MEM_IDX: next_s.mem_idx = 7'(wmerge(32'(s.mem_idx), s.w_data, s.w_strb));
        `XG_REG_MEM_WLO: next_s.mem_wlo = wmerge(s.mem_wlo, s.w_data, s.w_strb);
        `XG_REG_MEM_WHI: begin
          // Direct frame writes only when no save or restore owns the port
          if (s.fsm == ST_IDLE) begin
            mem_we    = 1'b1;
            mem_addr  = s.mem_idx;
            mem_wdata = {s.w_data, s.mem_wlo};
          end
        end
        default: ;  // Writes to the save-map word are dropped
      endcase
    end
    if (s.rsp.rvalid && axil_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (axil_req.arvalid && s.rsp.arready) begin
      case (raddr)
        `XG_REG_CTRL:     rd_data = 32'(s.ctrl);
        `XG_REG_MASK_LO:  rd_data = s.mask[31:0];
        `XG_REG_MASK_HI:  rd_data = s.mask[63:32];
        `XG_REG_XCR_LO:   rd_data = s.xcr[31:0];
        `XG_REG_XCR_HI:   rd_data = s.xcr[63:32];
        `XG_REG_PAGES:    rd_data = 32'(s.pages);
        `XG_REG_MISC:     rd_data = s.misc;
        `XG_REG_ASEL_LO:  rd_data = s.attr_sel[31:0];
        `XG_REG_ASEL_HI:  rd_data = s.attr_sel[63:32];
        `XG_REG_MSEL:     rd_data = s.misc_sel;
        `XG_REG_LFCS:     rd_data = s.live_fcs;
        `XG_REG_LBM_LO:   rd_data = s.live_bm[31:0];
        `XG_REG_LBM_HI:   rd_data = s.live_bm[63:32];
        `XG_REG_STATUS:   rd_data = 32'({s.wide_used, s.intr_ei, s.exit_reason_ei, s.save_map_ei,
                                         s.system_management_mode, s.in_enclave, s.fault, s.fsm != ST_IDLE});
        `XG_REG_SXCR_LO:  rd_data = s.saved_xcr[31:0];
        `XG_REG_SXCR_HI:  rd_data = s.saved_xcr[63:32];
        `XG_REG_MOD_LO:   rd_data = s.modified[31:0];
        `XG_REG_MOD_HI:   rd_data = s.modified[63:32];
        `XG_REG_RMASK_LO: rd_data = s.rep_mask[31:0];
        `XG_REG_RMASK_HI: rd_data = s.rep_mask[63:32];
        `XG_REG_RMISC:    rd_data = s.rep_misc;
        `XG_REG_KMASK_LO: rd_data = s.key_mask[31:0];
        `XG_REG_KMASK_HI: rd_data = s.key_mask[63:32];
        `XG_REG_KMISC:    rd_data = s.key_misc;
        `XG_REG_MEM_IDX:  rd_data = 32'(s.mem_idx);
        `XG_REG_MEM_WLO:  rd_data = s.mem_wlo;
        `XG_REG_SBM_LO:   rd_data = s.saved_bm[31:0];
        `XG_REG_SBM_HI:   rd_data = s.saved_bm[63:32];
        `XG_REG_SAVE_MAP: rd_data = 32'(s.save_map_ei) << `XG_SMAP_EI_BIT;
        default:          rd_data = '0;
      endcase
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = rd_data;
      next_s.rsp.rresp  = (raddr > `XG_REG_LAST) ? `XG_RESP_DECERR : `XG_RESP_OKAY;
    end
    if (cmd_go) begin
      next_s.fault = `XG_FLT_NONE;
      if (s.system_management_mode && is_instr(cmd_op)) begin
        next_s.fault = `XG_FLT_UD;
      end else begin
        case (cmd_op)
          `XG_OP_CREATE: begin
            if (create_gp) next_s.fault = `XG_FLT_GP;
          end
          `XG_OP_ENTER: begin
            if (s.in_enclave || entry_gp) begin
              next_s.fault = `XG_FLT_GP;
            end else begin
              next_s.saved_xcr  = s.xcr;
              next_s.xcr        = s.mask;
              next_s.in_enclave = 1'b1;
            end
          end
          `XG_OP_RESUME: begin
            if (s.in_enclave || entry_gp) next_s.fault = `XG_FLT_GP;
            else next_s.fsm = ST_RD_FCS;
          end
          `XG_OP_EXIT: begin
            if (!s.in_enclave) begin
              next_s.fault = `XG_FLT_GP;
            end else begin
              next_s.xcr        = s.saved_xcr;
              next_s.in_enclave = 1'b0;
            end
          end
          `XG_OP_AEX: begin
            if (s.in_enclave) begin
              next_s.fsm      = ST_SV_FCS;
              next_s.smi_pend = 1'b0;
            end
          end
          `XG_OP_SMI: begin
            if (s.system_management_mode) begin
              next_s.fault = `XG_FLT_NONE;
            end else if (s.in_enclave) begin
              next_s.fsm      = ST_SV_FCS;
              next_s.smi_pend = 1'b1;
            end else begin
              next_s.system_management_mode            = 1'b1;
              next_s.save_map_ei    = 1'b0;
              next_s.exit_reason_ei = 1'b0;
              next_s.intr_ei        = 1'b0;
            end
          end
          `XG_OP_REPORT: begin
            if (!s.in_enclave) begin
              next_s.fault = `XG_FLT_GP;
            end else begin
              next_s.rep_mask = s.mask;
              next_s.rep_misc = s.misc;
            end
          end
          `XG_OP_KEY: begin
            if (!s.in_enclave) begin
              next_s.fault = `XG_FLT_GP;
            end else begin
              next_s.key_mask = s.mask & s.attr_sel;
              next_s.key_misc = s.misc & s.misc_sel;
            end
          end
          `XG_OP_LEAVE: next_s.system_management_mode = 1'b0;
          default: next_s.fault = `XG_FLT_UD;
        endcase
      end
    end
    case (s.fsm)
      // Idle keeps whatever state a command just started
      ST_IDLE: ;
      ST_SV_FCS: begin
        mem_we     = 1'b1;
        mem_addr   = `XG_IDX_FCS;
        mem_wdata  = 64'(s.live_fcs);
        next_s.fsm = ST_SV_BM;
      end
      ST_SV_BM: begin
        mem_we          = 1'b1;
        mem_addr        = `XG_IDX_BM;
        // Without xsave this word is the mask copy; with it the saved bitmap
        mem_wdata       = sup ? (s.live_bm & s.mask) : s.mask;
        next_s.saved_bm = mem_wdata;
        next_s.fsm      = ST_SV_HDR;
      end
      ST_SV_HDR: begin
        mem_we            = 1'b1;
        mem_addr          = `XG_IDX_HDR;
        mem_wdata         = '0;
        next_s.xcr        = s.saved_xcr;
        next_s.live_fcs   = `XG_FCS_INIT;
        next_s.live_bm    = s.live_bm & ~s.mask;
        next_s.in_enclave = 1'b0;
        next_s.wide_used  = s.ctrl[`XG_CTL_WIDE];
        if (s.smi_pend) begin
          next_s.system_management_mode            = 1'b1;
          next_s.save_map_ei    = 1'b1;
          next_s.exit_reason_ei = s.ctrl[`XG_CTL_DUAL];
          next_s.intr_ei        = s.ctrl[`XG_CTL_DUAL];
          next_s.smi_pend       = 1'b0;
        end
        next_s.fsm = ST_IDLE;
      end
      ST_RD_FCS: begin
        mem_addr   = `XG_IDX_FCS;
        next_s.fsm = ST_RD_BM;
      end
      ST_RD_BM: begin
        mem_addr      = `XG_IDX_BM;
        next_s.rd_fcs = mem_rdata[31:0];
        next_s.fsm    = ST_RD_HDR;
      end
      ST_RD_HDR: begin
        mem_addr     = `XG_IDX_HDR;
        next_s.rd_bm = mem_rdata;
        next_s.fsm   = ST_RD_CHK;
      end
      ST_RD_CHK: begin
        mem_addr = `XG_IDX_HDR;
        if (res_bad) begin
          next_s.fault = `XG_FLT_GP;
        end else begin
          next_s.saved_xcr  = s.xcr;
          next_s.xcr        = s.mask;
          next_s.live_fcs   = s.rd_fcs;
          next_s.live_bm    = s.rd_bm & s.mask;
          next_s.modified   = s.mask;
          next_s.in_enclave = 1'b1;
          next_s.wide_used  = s.ctrl[`XG_CTL_WIDE];
        end
        next_s.fsm = ST_IDLE;
      end
      default: next_s.fsm = ST_IDLE;
    endcase
    next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.w_held && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.fsm      <= ST_IDLE;
      s.live_fcs <= `XG_FCS_INIT;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_create_low_bits: assert property (cmd_go && cmd_op == `XG_OP_CREATE && !s.system_management_mode
      && s.mask[1:0] != `XG_MASK_BASE |=> s.fault == `XG_FLT_GP)
    else $error("create with bad low mask bits did not fault");
  a_create_no_frame: assert property (cmd_go && cmd_op == `XG_OP_CREATE && !s.system_management_mode
      && !sup && s.pages == '0 |=> s.fault == `XG_FLT_GP)
    else $error("create with zero frame did not fault");
  a_create_top_bit: assert property (cmd_go && cmd_op == `XG_OP_CREATE && !s.system_management_mode
      && sup && s.mask[63] |=> s.fault == `XG_FLT_GP)
    else $error("create with mask bit 63 did not fault");
  a_enter_fault_keep: assert property (cmd_go && cmd_op == `XG_OP_ENTER && !s.system_management_mode
      && entry_gp && !s.in_enclave
      |=> s.fault == `XG_FLT_GP && s.xcr == $past(s.xcr) && !s.in_enclave)
    else $error("faulting entry changed state");
  a_enter_swap: assert property (cmd_go && cmd_op == `XG_OP_ENTER && !s.system_management_mode
      && !entry_gp && !s.in_enclave |=> s.xcr == $past(s.mask)
      && s.saved_xcr == $past(s.xcr) && s.in_enclave)
    else $error("entry did not swap control register");
  a_aex_bitmap: assert property (mem_we && s.fsm == ST_SV_BM && sup
      |-> (mem_wdata & ~s.mask) == '0)
    else $error("saved bitmap outside mask");
  a_aex_restore: assert property (s.fsm == ST_SV_FCS ##1 s.fsm == ST_SV_BM
      |=> ##1 s.xcr == $past(s.saved_xcr) && !s.in_enclave && s.live_fcs == `XG_FCS_INIT)
    else $error("async exit did not restore and synthesize");
  a_resume_modified: assert property (s.fsm == ST_RD_CHK && !res_bad
      |=> s.modified == $past(s.mask) && s.xcr == $past(s.mask) && s.in_enclave)
    else $error("resume did not mark state modified");
  a_smm_invalid_op: assert property (cmd_go && s.system_management_mode && is_instr(cmd_op)
      |=> s.fault == `XG_FLT_UD && $stable(s.xcr))
    else $error("instruction in management mode did not raise invalid opcode");
  a_key_masked: assert property (cmd_go && cmd_op == `XG_OP_KEY && s.in_enclave && !s.system_management_mode
      |=> s.key_mask == ($past(s.mask) & $past(s.attr_sel)))
    else $error("key mask not selected");
  a_bvalid_hold: assert property (s.rsp.bvalid && !axil_req.bready |=> s.rsp.bvalid)
    else $error("write response dropped");

  c_resume_ok: cover property (s.fsm == ST_RD_CHK && !res_bad);
  c_resume_bad: cover property (s.fsm == ST_RD_CHK && res_bad);
  c_smi_enclave: cover property (s.fsm == ST_SV_HDR && s.smi_pend);
  c_create_ok: cover property (cmd_go && cmd_op == `XG_OP_CREATE && !create_gp && !s.system_management_mode);
endmodule
`default_nettype wire

// file: tb/test_enclave_xstate_guard.sv
// Register-level bench for the enclave extended-state guard
`timescale 1ns/1ps
`default_nettype none
module test_enclave_xstate_guard;
  import xg_pkg::*;
  logic      aclk = 1'b0;
  logic      aresetn = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [31:0] rv;
  logic [1:0]  rp;
  int          fail_count = 0;
  int          checked = 0;

  always #20 aclk = ~aclk;

  enclave_xstate_guard dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .axil_req(req),
    .axil_rsp(rsp)
  );

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address and data offered together; each released on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic dn;
    dn = 1'b0;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50 && !dn; n++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        dn = 1'b1;
        req.bready <= 1'b0;
      end
    end
    if (!dn) begin
      fail_count++;
      close_out();
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    int   n;
    logic dn;
    dn = 1'b0;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 50 && !dn; n++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        dn = 1'b1;
        rv = rsp.rdata;
        rp = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
    if (!dn) begin
      fail_count++;
      close_out();
    end
    @(posedge aclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk("reg", rv, exp);
  endtask

  // Busy only matters for async exit, management interrupt in enclave and resume; polling keeps one path for all
  task automatic op(input logic [3:0] c);
    int n;
    wr(8'h34, {28'h0, c});
    rv = 32'h1;
    for (n = 0; n < 20 && rv[0] !== 1'b0; n++) rd(8'h38);
    rd(8'h38);
    chk("busy", rv & 32'h1, 32'h0);
  endtask

  task automatic st(input logic [31:0] exp);
    rd(8'h38);
    chk("status", rv & 32'h1F, exp);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    st(32'h0);
    rc(8'h28, 32'h1F80);
    rd(8'h7C);
    chk("decerr", {30'h0, rp}, 32'h3);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h7);
    op(4'h0);
    st(32'h2);
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h6);
    op(4'h0);
    st(32'h2);
    wr(8'h00, 32'h7);
    wr(8'h08, 32'h8000_0000);
    op(4'h0);
    st(32'h2);
    wr(8'h08, 32'h0);
    op(4'h0);
    st(32'h0);
    wr(8'h0C, 32'h3);
    op(4'h1);
    st(32'h2);
    rc(8'h0C, 32'h3);
    wr(8'h0C, 32'hF);
    op(4'h1);
    st(32'h8);
    rc(8'h0C, 32'h7);
    rc(8'h3C, 32'hF);
    wr(8'h18, 32'h3);
    op(4'h6);
    rc(8'h4C, 32'h7);
    rc(8'h54, 32'h3);
    wr(8'h28, 32'h0000_1234);
    wr(8'h2C, 32'h0000_000D);
    op(4'h4);
    st(32'h0);
    rc(8'h0C, 32'hF);
    rc(8'h28, 32'h1F80);
    rc(8'h2C, 32'h8);
    rc(8'h70, 32'h5);
    op(4'h2);
    st(32'h8);
    rc(8'h0C, 32'h7);
    rc(8'h44, 32'h7);
    rc(8'h28, 32'h0000_1234);
    rc(8'h2C, 32'h5);
    wr(8'h1C, 32'h5);
    wr(8'h24, 32'h1);
    op(4'h7);
    rc(8'h58, 32'h5);
    rc(8'h60, 32'h1);
    op(4'h3);
    rc(8'h0C, 32'hF);
    op(4'h1);
    op(4'h5);
    rc(8'h78, 32'h2);
    rc(8'h38, 32'h30);
    wr(8'h78, 32'h0);
    rc(8'h78, 32'h2);
    op(4'h0);
    st(32'h14);
    op(4'h8);
    st(32'h0);
    // Corrupt the frame header so that the next resume must refuse it
    wr(8'h64, 32'h41);
    wr(8'h68, 32'h1);
    wr(8'h6C, 32'h0);
    op(4'h2);
    st(32'h2);
    rc(8'h0C, 32'hF);
    wr(8'h00, 32'h2);
    op(4'h1);
    op(4'h4);
    rc(8'h70, 32'h7);
    wr(8'h00, 32'h17);
    op(4'h1);
    op(4'h5);
    rc(8'h38, 32'hF0);
    op(4'h8);
    st(32'h0);
    close_out();
  end
endmodule
`default_nettype wire
